// *** tpg_pkg.sv ***
package tpg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [8:0] OFS_A_DATA    = 9'h005;
  localparam logic [8:0] OFS_B_DATA    = 9'h006;
  localparam logic [8:0] OFS_B_DATA_HI = 9'h106;
  localparam logic [8:0] OFS_C_DATA    = 9'h007;
  localparam logic [8:0] OFS_OPTION    = 9'h081;
  localparam logic [8:0] OFS_OPTION_HI = 9'h181;
  localparam logic [8:0] OFS_A_DIR     = 9'h085;
  localparam logic [8:0] OFS_B_DIR     = 9'h086;
  localparam logic [8:0] OFS_B_DIR_HI  = 9'h186;
  localparam logic [8:0] OFS_C_DIR     = 9'h087;
  localparam logic [8:0] OFS_ANALOG    = 9'h09f;
  localparam logic [8:0] OFS_IRQ_CTRL  = 9'h00b;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int         OPT_PULLUP_N_BIT = 7;
  localparam int         OPT_EDGE_BIT     = 6;
  localparam int         IRQ_CHANGE_BIT   = 0;
  localparam int         IRQ_EXT_BIT      = 1;
  localparam int         ANALOG_ADFM_BIT  = 7;
  localparam logic [7:0] OPTION_RST       = 8'hff;
  localparam logic [5:0] A_DIR_RST        = 6'h3f;
  localparam logic [7:0] DIR_RST          = 8'hff;
  localparam logic [7:0] ANALOG_RST       = 8'h00;
  localparam logic [7:0] ANALOG_MASK      = 8'h8f;
  localparam logic [3:0] CHANGE_MASK      = 4'hf;
  localparam logic [7:0] ZERO8            = 8'h00;
  localparam logic [3:0] ALL_DIGITAL_A    = 4'h6;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tpg_bus_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } tpg_pins_t;

endpackage

// *** tpg_gpio.sv ***
// Operation
// - Port B eight bidirectional bits
// - B direction one floats, zero drives latch
// - Port C eight bits, same direction rule
// - Option bit 7 low enables B pull-ups
// - Output pins lose their pull-up
// - Power-on: pull-ups off, option all ones
// - Only input pins 7:4 detect change
// - Compare against value latched at read
// - OR of mismatches sets change flag
// - Change flag wakes device from sleep
// - Any B read or write refreshes latch
// - Flag re-sets while mismatch persists
// - B pin 0 external irq, option bit 6 edge
// - Peripheral overrides C direction bit
// - Select muxes latch or peripheral output
// - B and C directions reset to ones
// - B, dir, option at two addresses
// - A bits 7:6 read zero, dir 3f
// - Port A six bidirectional bits
// - Reads return pins, writes update latch
// - Power-on: A analog pins read zero
`timescale 1ns/1ps
`default_nettype none

module tpg_gpio (
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  input  wire logic       POR,
  input  wire logic [8:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  input  wire logic [5:0] PA_IN,
  output var  logic [5:0] PA_OUT,
  output var  logic [5:0] PA_OE,
  input  wire logic [7:0] PB_IN,
  output var  logic [7:0] PB_OUT,
  output var  logic [7:0] PB_OE,
  output var  logic [7:0] PB_PULLUP,
  input  wire logic [7:0] PC_IN,
  output var  logic [7:0] PC_OUT,
  output var  logic [7:0] PC_OE,
  input  wire logic [7:0] PERIPH_SEL,
  input  wire logic [7:0] PERIPH_OUT,
  input  wire logic [7:0] PERIPH_OE,
  input  wire logic [7:0] PERIPH_FORCE_IN,
  output var  logic       CHANGE_IRQ,
  output var  logic       EXT_IRQ,
  output var  logic       WAKE,
  output var  logic [3:0] ANALOG_CFG
);

  // ****************************************
  // Bus decode
  // ****************************************
  tpg_pkg::tpg_bus_t bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  function automatic logic hit(input logic [8:0] a, input logic [8:0] lo, input logic [8:0] hi);
    hit = (a == lo) || (a == hi);
  endfunction

  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_opt;
  logic wr_adir;
  logic wr_bdir;
  logic wr_cdir;
  logic wr_an;
  logic wr_irq;
  logic rd_b;
  assign wr_a    = bus.wr && bus.addr == tpg_pkg::OFS_A_DATA;
  assign wr_b    = bus.wr && hit(bus.addr, tpg_pkg::OFS_B_DATA, tpg_pkg::OFS_B_DATA_HI);
  assign wr_c    = bus.wr && bus.addr == tpg_pkg::OFS_C_DATA;
  assign wr_opt  = bus.wr && hit(bus.addr, tpg_pkg::OFS_OPTION, tpg_pkg::OFS_OPTION_HI);
  assign wr_adir = bus.wr && bus.addr == tpg_pkg::OFS_A_DIR;
  assign wr_bdir = bus.wr && hit(bus.addr, tpg_pkg::OFS_B_DIR, tpg_pkg::OFS_B_DIR_HI);
  assign wr_cdir = bus.wr && bus.addr == tpg_pkg::OFS_C_DIR;
  assign wr_an   = bus.wr && bus.addr == tpg_pkg::OFS_ANALOG;
  assign wr_irq  = bus.wr && bus.addr == tpg_pkg::OFS_IRQ_CTRL;
  assign rd_b    = bus.rd && hit(bus.addr, tpg_pkg::OFS_B_DATA, tpg_pkg::OFS_B_DATA_HI);

  // ****************************************
  // Registers
  // ****************************************
  logic [5:0] a_lat_q;
  logic [5:0] a_dir_q;
  logic [7:0] b_lat_q;
  logic [7:0] b_dir_q;
  logic [7:0] c_lat_q;
  logic [7:0] c_dir_q;
  logic [7:0] opt_q;
  logic [7:0] an_q;

  // ****************************************
  // Data latches
  // ****************************************
  // Latches keep their value on every reset; power-on value is arbitrary
  always_ff @(posedge REF_CLK) begin
    if (wr_a) begin
      a_lat_q <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (wr_b) begin
      b_lat_q <= bus.wdata;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (wr_c) begin
      c_lat_q <= bus.wdata;
    end
  end

  // ****************************************
  // Direction and option registers
  // ****************************************
  // Every reset returns the pins to inputs, so nothing drives before software asks
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      a_dir_q <= tpg_pkg::A_DIR_RST;
    end else if (wr_adir) begin
      a_dir_q <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      b_dir_q <= tpg_pkg::DIR_RST;
    end else if (wr_bdir) begin
      b_dir_q <= bus.wdata;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      c_dir_q <= tpg_pkg::DIR_RST;
    end else if (wr_cdir) begin
      c_dir_q <= bus.wdata;
    end
  end

  // Option resets to all ones, which also leaves the pull-ups off
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      opt_q <= tpg_pkg::OPTION_RST;
    end else if (wr_opt) begin
      opt_q <= bus.wdata;
    end
  end

  // Analog config only cleared on power-on, as other resets leave it
  always_ff @(posedge REF_CLK) begin
    if (RESET && POR) begin
      an_q <= tpg_pkg::ANALOG_RST;
    end else if (wr_an) begin
      an_q <= bus.wdata & tpg_pkg::ANALOG_MASK;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic [7:0] c_oe_d, c_out_d;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (PERIPH_SEL[i]) begin
        c_out_d[i] = PERIPH_OUT[i];
        c_oe_d[i]  = PERIPH_OE[i] && !PERIPH_FORCE_IN[i];
      end else begin
        c_out_d[i] = c_lat_q[i];
        c_oe_d[i]  = !c_dir_q[i];
      end
    end
  end

  // ****************************************
  // Port A drive
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PA_OE  <= '0;
      PA_OUT <= '0;
    end else begin
      PA_OE  <= ~a_dir_q;
      PA_OUT <= a_lat_q;
    end
  end

  // ****************************************
  // Port B drive and pull-ups
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PB_OE  <= '0;
      PB_OUT <= '0;
    end else begin
      PB_OE  <= ~b_dir_q;
      PB_OUT <= b_lat_q;
    end
  end

  // Pull-up follows the direction bit, so a pin never pulls against its own driver
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PB_PULLUP <= '0;
    end else begin
      PB_PULLUP <= {8{~opt_q[tpg_pkg::OPT_PULLUP_N_BIT]}} & b_dir_q;
    end
  end

  // ****************************************
  // Port C drive
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PC_OE  <= '0;
      PC_OUT <= '0;
    end else begin
      PC_OE  <= c_oe_d;
      PC_OUT <= c_out_d;
    end
  end

  // ****************************************
  // Change detect and external interrupt
  // ****************************************
  logic [3:0] snap_q;
  logic [3:0] mismatch;
  logic       chg_q;
  logic       ext_q;
  logic       pin0_q;
  logic       ext_edge;
  logic       clr_chg;
  logic       clr_ext;
  // Snapshot refreshed on any port B access; polling ends a mismatch but cannot hide a change from the flag
  // Reset takes the pins as they stand, so no false mismatch follows it
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      snap_q <= PB_IN[7:4];
    end else if (rd_b || wr_b) begin
      snap_q <= PB_IN[7:4];
    end
  end
  assign mismatch = (PB_IN[7:4] ^ snap_q) & b_dir_q[7:4] & tpg_pkg::CHANGE_MASK;

  // ****************************************
  // External interrupt edge
  // ****************************************
  // Sampled through reset too, so a pin idling high gives no false edge
  always_ff @(posedge REF_CLK) begin
    pin0_q <= PB_IN[0];
  end

  assign ext_edge = opt_q[tpg_pkg::OPT_EDGE_BIT] ? (PB_IN[0] && !pin0_q)
                                                : (!PB_IN[0] && pin0_q);

  // ****************************************
  // Interrupt flags
  // ****************************************
  // Writing zero clears a flag; writing one leaves it alone
  function automatic logic sw_clear(input logic w, input logic [7:0] d, input int b);
    sw_clear = w && !d[b];
  endfunction

  assign clr_chg = sw_clear(wr_irq, bus.wdata, tpg_pkg::IRQ_CHANGE_BIT);
  assign clr_ext = sw_clear(wr_irq, bus.wdata, tpg_pkg::IRQ_EXT_BIT);

  // Set wins over a software clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      chg_q <= '0;
    end else begin
      chg_q <= (|mismatch) || (chg_q && !clr_chg);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ext_q <= '0;
    end else begin
      ext_q <= ext_edge || (ext_q && !clr_ext);
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CHANGE_IRQ <= '0;
    end else begin
      CHANGE_IRQ <= chg_q;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      EXT_IRQ <= '0;
    end else begin
      EXT_IRQ <= ext_q;
    end
  end

  // Own flop, so the sleeping core sees wake without any gating in between
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      WAKE <= '0;
    end else begin
      WAKE <= chg_q || ext_q;
    end
  end

  // ****************************************
  // Analog configuration
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ANALOG_CFG <= '0;
    end else begin
      ANALOG_CFG <= an_q[3:0];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  function automatic logic [7:0] pins_a(input logic [5:0] p, input logic [3:0] cfg);
    // Analog-configured pins read zero; only all-digital codes expose them
    pins_a = (cfg[3:1] == tpg_pkg::ALL_DIGITAL_A[3:1]) ? {2'h0, p} : {3'h0, p[4], 4'h0};
  endfunction

  logic [7:0] rd_d;
  always_comb begin
    rd_d = tpg_pkg::ZERO8;
    if (bus.rd) begin
      unique case (1'b1)
        bus.addr == tpg_pkg::OFS_A_DATA: rd_d = pins_a(PA_IN, an_q[3:0]);
        hit(bus.addr, tpg_pkg::OFS_B_DATA, tpg_pkg::OFS_B_DATA_HI): rd_d = PB_IN;
        bus.addr == tpg_pkg::OFS_C_DATA: rd_d = PC_IN;
        hit(bus.addr, tpg_pkg::OFS_OPTION, tpg_pkg::OFS_OPTION_HI): rd_d = opt_q;
        bus.addr == tpg_pkg::OFS_A_DIR: rd_d = {2'h0, a_dir_q};
        hit(bus.addr, tpg_pkg::OFS_B_DIR, tpg_pkg::OFS_B_DIR_HI): rd_d = b_dir_q;
        bus.addr == tpg_pkg::OFS_C_DIR: rd_d = c_dir_q;
        bus.addr == tpg_pkg::OFS_ANALOG: rd_d = an_q;
        bus.addr == tpg_pkg::OFS_IRQ_CTRL: rd_d = {6'h00, ext_q, chg_q};
        default: rd_d = tpg_pkg::ZERO8;
      endcase
    end
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      RDATA <= '0;
    end else begin
      RDATA <= rd_d;
    end
  end

endmodule

`default_nettype wire

// *** tpg_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Board side of one port
// ****
module tpg_pins_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] drv,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pin
);
  // Board always drives undriven pins, so no floating level reaches the core
  assign pin = (oe & drv) | (~oe & ext);
endmodule
`default_nettype wire

// *** tpg_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module tpg_chk (
  input wire logic       REF_CLK,
  input wire logic       RESET,
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] PB_OE,
  input wire logic [7:0] PB_PULLUP,
  input wire logic [7:0] PC_OE,
  input wire logic [7:0] PERIPH_SEL,
  input wire logic [7:0] PERIPH_OE,
  input wire logic [7:0] PERIPH_FORCE_IN,
  input wire logic       CHANGE_IRQ,
  input wire logic       EXT_IRQ,
  input wire logic       WAKE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence s_wr(a);
    WR && ADDR == a;
  endsequence
  sequence s_plain_c;
    PERIPH_SEL == 8'h00;
  endsequence
  chk_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its slot");
  chk_a_upper: assert property (RD && ADDR == tpg_pkg::OFS_A_DATA |=> RDATA[7:6] == 2'h0)
    else $error("port A upper bits not zero");
  chk_b_dir: assert property ((s_wr(tpg_pkg::OFS_B_DIR) or s_wr(tpg_pkg::OFS_B_DIR_HI))
    |-> ##2 PB_OE == ~$past(WDATA, 2)) else $error("port B enable wrong");
  chk_pull_out: assert property ((PB_PULLUP & PB_OE) == 8'h00)
    else $error("pull-up on output pin");
  chk_c_dir: assert property ((s_wr(tpg_pkg::OFS_C_DIR) and s_plain_c) ##1 s_plain_c
    |=> PC_OE == ~$past(WDATA, 2)) else $error("port C enable wrong");
  chk_c_owned: assert property (PERIPH_SEL == 8'hff
    |=> PC_OE == ($past(PERIPH_OE) & ~$past(PERIPH_FORCE_IN))) else $error("override wrong");
  chk_wake_src: assert property (WAKE == (CHANGE_IRQ || EXT_IRQ))
    else $error("wake not tied to flags");
  chk_chg_hold: assert property ($fell(CHANGE_IRQ)
    |-> $past(WR, 2) && $past(ADDR, 2) == tpg_pkg::OFS_IRQ_CTRL) else $error("flag lost");
endmodule
bind tpg_gpio tpg_chk u_tpg_chk (.REF_CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .PB_OE,
  .PB_PULLUP, .PC_OE, .PERIPH_SEL, .PERIPH_OE, .PERIPH_FORCE_IN, .CHANGE_IRQ, .EXT_IRQ, .WAKE);
`default_nettype wire

// *** tpg_gpio_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tpg_gpio_test;
  logic       clk = 1'b0, reset = 1'b1, por = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00, b_ext = 8'h00, sel = 8'h00, p_out = 8'h00, p_oe = 8'h00;
  logic [7:0] p_in = 8'h00, c_ext = 8'h00, rdata, pb_out, pb_oe, pb_pu, pb_in, pc_out, pc_oe;
  logic [7:0] pc_in;
  logic [5:0] a_ext = 6'h3f, pa_out, pa_oe, pa_in;
  logic       chg, ext, wake;
  logic [3:0] acfg;
  int         n_fail = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  tpg_gpio u_tpg_gpio (.REF_CLK(clk), .RESET(reset), .POR(por), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe),
    .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .PB_PULLUP(pb_pu), .PC_IN(pc_in),
    .PC_OUT(pc_out), .PC_OE(pc_oe), .PERIPH_SEL(sel), .PERIPH_OUT(p_out), .PERIPH_OE(p_oe),
    .PERIPH_FORCE_IN(p_in), .CHANGE_IRQ(chg), .EXT_IRQ(ext), .WAKE(wake), .ANALOG_CFG(acfg));
  tpg_pins_model #(.W(6)) u_pa (.oe(pa_oe), .drv(pa_out), .ext(a_ext), .pin(pa_in));
  tpg_pins_model #(.W(8)) u_pb (.oe(pb_oe), .drv(pb_out), .ext(b_ext), .pin(pb_in));
  tpg_pins_model #(.W(8)) u_pc (.oe(pc_oe), .drv(pc_out), .ext(c_ext), .pin(pc_in));
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // Latch, output flop and one spare edge
  task settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task t_reset;
    rd_reg(tpg_pkg::OFS_OPTION, 8'hff);
    rd_reg(tpg_pkg::OFS_B_DIR, 8'hff);
    rd_reg(tpg_pkg::OFS_C_DIR, 8'hff);
    rd_reg(tpg_pkg::OFS_A_DIR, 8'h3f);
    rd_reg(tpg_pkg::OFS_A_DATA, 8'h10);
    rd_reg(9'h0ff, 8'h00);
    chk(pb_pu, 8'h00);
  endtask
  task t_pullup;
    wr_reg(tpg_pkg::OFS_OPTION, 8'h7f);
    wr_reg(tpg_pkg::OFS_B_DIR, 8'h07);
    settle;
    chk(pb_pu, 8'h07);
    chk(pb_oe, 8'hf8);
    wr_reg(tpg_pkg::OFS_OPTION_HI, 8'hff);
    rd_reg(tpg_pkg::OFS_OPTION, 8'hff);
    chk(pb_pu, 8'h00);
  endtask
  task t_bdata;
    wr_reg(tpg_pkg::OFS_B_DATA, 8'ha5);
    wr_reg(tpg_pkg::OFS_B_DIR_HI, 8'h00);
    settle;
    chk(pb_oe, 8'hff);
    chk(pb_out, 8'ha5);
    rd_reg(tpg_pkg::OFS_B_DATA_HI, 8'ha5);
    wr_reg(tpg_pkg::OFS_B_DIR, 8'hff);
  endtask
  // No polling of port B while waiting for the change flag
  task t_change;
    rd_reg(tpg_pkg::OFS_B_DATA, 8'h00);
    wr_reg(tpg_pkg::OFS_IRQ_CTRL, 8'h00);
    @(posedge clk);
    b_ext <= 8'h01;
    settle;
    chk({7'h00, chg}, 8'h00);
    @(posedge clk);
    b_ext <= 8'h21;
    settle;
    chk({6'h00, wake, chg}, 8'h03);
    wr_reg(tpg_pkg::OFS_IRQ_CTRL, 8'h00);
    settle;
    chk({7'h00, chg}, 8'h01);
    rd_reg(tpg_pkg::OFS_B_DATA, 8'h21);
    wr_reg(tpg_pkg::OFS_IRQ_CTRL, 8'h00);
    wr_reg(tpg_pkg::OFS_B_DIR, 8'h7f);
    settle;
    chk({7'h00, chg}, 8'h00);
  endtask
  task t_ext;
    wr_reg(tpg_pkg::OFS_B_DIR, 8'hff);
    @(posedge clk);
    b_ext <= 8'h20;
    settle;
    chk({7'h00, ext}, 8'h00);
    @(posedge clk);
    b_ext <= 8'h21;
    settle;
    chk({7'h00, ext}, 8'h01);
    wr_reg(tpg_pkg::OFS_IRQ_CTRL, 8'h00);
    wr_reg(tpg_pkg::OFS_OPTION, 8'hbf);
    settle;
    chk({7'h00, ext}, 8'h00);
    @(posedge clk);
    b_ext <= 8'h20;
    settle;
    chk({7'h00, ext}, 8'h01);
  endtask
  task t_pin_group_c_data;
    wr_reg(tpg_pkg::OFS_C_DATA, 8'h3c);
    wr_reg(tpg_pkg::OFS_C_DIR, 8'h00);
    settle;
    chk(pc_out, 8'h3c);
    chk(pc_oe, 8'hff);
    @(posedge clk);
    sel <= 8'hff;
    p_out <= 8'h99;
    p_oe <= 8'h0f;
    p_in <= 8'h03;
    settle;
    chk(pc_out, 8'h99);
    chk(pc_oe, 8'h0c);
    wr_reg(tpg_pkg::OFS_C_DIR, 8'hff);
    settle;
    chk(pc_oe, 8'h0c);
  endtask
  task t_pin_group_a_data;
    wr_reg(tpg_pkg::OFS_ANALOG, 8'h06);
    wr_reg(tpg_pkg::OFS_A_DATA, 8'h2a);
    wr_reg(tpg_pkg::OFS_A_DIR, 8'h30);
    settle;
    chk({4'h0, acfg}, 8'h06);
    chk({2'h0, pa_oe}, 8'h0f);
    rd_reg(tpg_pkg::OFS_A_DATA, 8'h3a);
  endtask
  // Warm reset: directions back to inputs, latches kept
  task t_warm;
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_reg(tpg_pkg::OFS_B_DIR_HI, 8'hff);
    rd_reg(tpg_pkg::OFS_A_DATA, 8'h3f);
    chk(pb_out, 8'ha5);
  endtask
  // Ceiling far above the roughly 120 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    t_reset;
    t_pullup;
    t_bdata;
    t_change;
    t_ext;
    t_pin_group_c_data;
    t_pin_group_a_data;
    t_warm;
    print_verdict;
  end
endmodule
`default_nettype wire
